// ---- hw/pxs_regs.vh ----
`ifndef PXS_REGS_VH
`define PXS_REGS_VH

// Register byte offsets
`define PXS_CTRL_ADDR      8'h00
`define PXS_DPTR_ADDR      8'h04
`define PXS_DIMS_ADDR      8'h08
`define PXS_PITCH_ADDR     8'h0c
`define PXS_PIXEL_WIDTH_REG_ADDR     8'h10
`define PXS_SOFF_ADDR      8'h14
`define PXS_STATUS_ADDR    8'h18
`define PXS_TOTAL_ADDR     8'h1c
`define PXS_RCOST_ADDR     8'h20

// Control fields
`define PXS_CTRL_START     0
`define PXS_CTRL_RESUME    1
`define PXS_CTRL_OP_LO     4
`define PXS_CTRL_OP_HI     5
`define PXS_CTRL_MASK      6
`define PXS_CTRL_TRANSP    7

// Status fields
`define PXS_ST_BUSY        0
`define PXS_ST_INTR        1
`define PXS_ST_CASE_LO     2
`define PXS_ST_CASE_HI     3
`define PXS_ST_LEAD        4
`define PXS_ST_TRAIL       5

// Reset values
`define PXS_CTRL_RST       32'h0000_0000
`define PXS_DPTR_RST       32'h0000_0000
`define PXS_DIMS_RST       32'h0000_0000
`define PXS_PITCH_RST      32'h0000_0000
`define PXS_PIXEL_WIDTH_REG_RST      32'h0000_0001
`define PXS_SOFF_RST       32'h0000_0000

// Clocks per machine state, then timing counts in machine states
`define PXS_MS_DIV         4'h2
`define PXS_FINAL_STATES   32'h0000_0003
`define PXS_FAST_OVH       32'h0000_0003
`define PXS_MED_SLOW_OVH   32'h0000_0005
`define PXS_LONG_SLOW_OVH  32'h0000_0007
`define PXS_LONG_SLOW_TAIL 32'h0000_0002
`define PXS_MEM_STATES     32'h0000_0002
`define PXS_ADJ_ONE        32'h0000_0002
`define PXS_ADJ_TWO        32'h0000_0004

// Case codes
`define PXS_CASE_SHORT     2'h0
`define PXS_CASE_MEDIUM    2'h1
`define PXS_CASE_LONG      2'h2

// Geometry
`define PXS_WORD_BITS      32'h0000_0010
`define PXS_SET_BITS       32'h0000_0020

`endif

// ---- hw/pxs_buf2.v ----
`timescale 1ns/100ps
module pxs_buf2 #(
  parameter W = 33
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg  [W-1:0] ent_ff [0:1];
  reg  [1:0]   cnt_ff;
  wire         push;
  wire         pop;

  assign in_ready_o  = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = ent_ff[0];

  // Head always in entry 0
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff    <= 2'h0;
      ent_ff[0] <= {W{1'b0}};
      ent_ff[1] <= {W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          ent_ff[cnt_ff[0]] <= in_data_i;
          cnt_ff            <= cnt_ff + 2'h1;
        end
        2'b01: begin
          ent_ff[0] <= ent_ff[1];
          cnt_ff    <= cnt_ff - 2'h1;
        end
        2'b11: begin
          if (cnt_ff == 2'h1) begin
            ent_ff[0] <= in_data_i;
          end else begin
            ent_ff[0] <= ent_ff[1];
            ent_ff[1] <= in_data_i;
          end
        end
        default: begin
          cnt_ff <= cnt_ff;
        end
      endcase
    end
  end
endmodule // pxs_buf2

// ---- hw/pxs_expand_seq.v ----
// Operation
// (RULE1) Use the short sequence when a source row fits one 16-bit word and touches one dest word.
// (RULE2) Short row cost is 3 plus 2 per source word plus G, times rows, plus 3 final states.
// (RULE3) Medium rows (source within 32 bits, several dest words) cost 3 or 5 plus 2R plus NG.
// (RULE4) Long rows run as serial 32-pixel sets without edge optimisation, then a short leftover.
// (RULE5) Long row cost is S sets of 3 or 7 plus 2R plus 2GP, plus 2V or 2+2V, plus NG.
// (RULE6) Each 32-bit source set takes two or three source reads by source alignment.
// (RULE7) Leftover bits take one, two or three source reads by count and alignment.
// (RULE8) Rows split into leading word, centre words and trailing word; trailing word sets class (code uses trailing word for medium rows, leading for long).
// (RULE9) Row count is the clipped row count held in the block dimensions register.
// (RULE10) Software keeps the destination pitch a multiple of 16 so every row aligns alike.
// (RULE11) Transfer walks one dest word at a time to increasing X and Y, ignoring direction bits.
// (RULE12) Dest words are read before replace when masking, transparency or processing is on.
// (RULE13) Masking, transparency and insertion together cost two states per dest word.
// (RULE14) G is 2, 4, 5 or 6 by operation, two more with masking or transparency.
// (RULE15) With masking or transparency, rows drop 2 states for B or C and 4 for D.
// (RULE16) Interrupts stop at word boundaries or row ends, set the flag and keep the context.
// (RULE17) Costs count machine states, one memory cycle being two states.
`timescale 1ns/100ps
`include "pxs_regs.vh"
module pxs_expand_seq (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_stb_i,
  input  wire        wb_cyc_i,
  output wire        wb_ack_o,
  input  wire        irq_req_i,
  output wire        mem_valid_o,
  input  wire        mem_ready_i,
  output wire [31:0] mem_addr_o,
  output wire        mem_rmw_o,
  output wire        busy_o,
  output wire        block_interrupted_flag_o
);
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_ROW   = 4'b0010;
  localparam [3:0] S_FINAL = 4'b0100;
  localparam [3:0] S_PAUSE = 4'b1000;
  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg         ack_ff;
  reg  [31:0] rdat_ff;
  reg  [31:0] ctrl_ff;
  reg  [31:0] dest_pointer_ff;
  reg  [31:0] block_dimensions_ff;
  reg  [31:0] dest_row_pitch_ff;
  reg  [31:0] pixel_width_reg_ff;
  reg  [31:0] src_off_ff;
  reg  [31:0] total_ff;
  reg  [31:0] row_cost_ff;
  reg  [31:0] row_words_ff;
  reg  [31:0] cost_left_ff;
  reg  [31:0] acc_ff;
  reg  [15:0] rows_left_ff;
  reg  [31:0] row_base_ff;
  reg  [31:0] addr_ff;
  reg         rmw_ff;
  reg         intr_ff;
  reg  [3:0]  div_ff;
  reg  [1:0]  case_ff;
  reg         lead_ff;
  reg         trail_ff;
  wire        bus_req;
  wire        wr_go;
  wire        ms_en;
  wire        buf_ready;
  wire        emit_due;
  wire        advance;
  wire [32:0] buf_data;
  wire [31:0] nacc;
  reg  [31:0] dx;
  reg  [31:0] psz;
  reg  [31:0] doff;
  reg  [31:0] soff;
  reg  [31:0] row_bits;
  reg  [31:0] n_words;
  reg  [31:0] g_val;
  reg  [31:0] r_words;
  reg  [31:0] sets;
  reg  [31:0] rem;
  reg  [31:0] r_set;
  reg  [31:0] v_words;
  reg  [31:0] n_rem;
  reg  [31:0] base_cost;
  reg  [31:0] adj;
  reg  [31:0] calc_cost;
  reg  [31:0] calc_words;
  reg  [1:0]  calc_case;
  reg         lead_mis;
  reg         trail_mis;
  reg         mask_on;
  function [31:0] wsel;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer i;
    begin
      wsel = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wsel[8*i +: 8] = new_v[8*i +: 8];
        end
      end
    end
  endfunction
  function [31:0] words_of;
    input [31:0] bits;
    begin
      words_of = (bits + 32'h0000_000f) >> 4;
    end
  endfunction
  function [31:0] gcost;
    input [1:0] op;
    input       mt;
    reg   [31:0] g;
    begin
      g = 32'h0000_0000;
      case (op)
        2'h0:    g = 32'h0000_0002;
        2'h1:    g = 32'h0000_0004;
        2'h2:    g = 32'h0000_0005;
        default: g = 32'h0000_0006;
      endcase
      gcost = mt ? (g + `PXS_MEM_STATES) : g; // RULE13
    end
  endfunction
  always @* begin
    dx        = {16'h0000, block_dimensions_ff[15:0]};
    psz       = {27'h0000000, pixel_width_reg_ff[4:0]};
    doff      = {28'h0000000, dest_pointer_ff[3:0]};
    soff      = {28'h0000000, src_off_ff[3:0]};
    row_bits  = dx * psz;
    n_words   = words_of(doff + row_bits);
    lead_mis  = (doff != 32'h0000_0000); // RULE8
    trail_mis = (((doff + row_bits) & 32'h0000_000f) != 32'h0000_0000); // RULE8
    mask_on   = ctrl_ff[`PXS_CTRL_MASK] | ctrl_ff[`PXS_CTRL_TRANSP];
    g_val     = gcost(ctrl_ff[`PXS_CTRL_OP_HI:`PXS_CTRL_OP_LO], mask_on); // RULE14
    r_words   = words_of(soff + dx);
    sets      = dx >> 5;
    rem       = dx & 32'h0000_001f;
    r_set     = (soff == 32'h0000_0000) ? 32'h0000_0002 : 32'h0000_0003; // RULE6
    v_words   = (rem == 32'h0000_0000) ? 32'h0000_0000 : words_of(soff + rem); // RULE7
    n_rem     = words_of(rem * psz);
    if ((soff + dx <= `PXS_WORD_BITS) && (n_words == 32'h0000_0001)) begin
      calc_case  = `PXS_CASE_SHORT; // RULE1
      base_cost  = `PXS_FAST_OVH + 32'h0000_0002 * r_words + g_val; // RULE2
      calc_words = 32'h0000_0001;
    end else if (dx <= `PXS_SET_BITS) begin
      calc_case  = `PXS_CASE_MEDIUM;
      base_cost  = (trail_mis ? `PXS_MED_SLOW_OVH : `PXS_FAST_OVH)
                 + 32'h0000_0002 * r_words + n_words * g_val; // RULE3
      calc_words = n_words;
    end else begin
      calc_case  = `PXS_CASE_LONG; // RULE4
      base_cost  = ((lead_mis ? `PXS_LONG_SLOW_OVH : `PXS_FAST_OVH)
                 + 32'h0000_0002 * r_set + 32'h0000_0002 * g_val * psz) * sets
                 + (lead_mis ? `PXS_LONG_SLOW_TAIL : 32'h0000_0000)
                 + 32'h0000_0002 * v_words + n_rem * g_val; // RULE5
      calc_words = 32'h0000_0002 * psz * sets + n_rem;
    end
    adj = 32'h0000_0000;
    if (mask_on && (calc_case != `PXS_CASE_SHORT)) begin
      if (lead_mis && trail_mis) begin
        adj = `PXS_ADJ_TWO; // RULE15
      end else if (lead_mis || trail_mis) begin
        adj = `PXS_ADJ_ONE; // RULE15
      end
    end
    calc_cost = (base_cost > adj + calc_words) ? (base_cost - adj) : calc_words;
  end
  assign bus_req  = wb_cyc_i & wb_stb_i;
  assign wr_go    = bus_req & wb_we_i & ~ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (bus_req & ~ack_ff & ~wb_we_i) begin
        case (wb_adr_i)
          `PXS_CTRL_ADDR:   rdat_ff <= ctrl_ff;
          `PXS_DPTR_ADDR:   rdat_ff <= dest_pointer_ff;
          `PXS_DIMS_ADDR:   rdat_ff <= block_dimensions_ff;
          `PXS_PITCH_ADDR:  rdat_ff <= dest_row_pitch_ff;
          `PXS_PIXEL_WIDTH_REG_ADDR:  rdat_ff <= pixel_width_reg_ff;
          `PXS_SOFF_ADDR:   rdat_ff <= src_off_ff;
          `PXS_STATUS_ADDR: rdat_ff <= {26'h0000000, trail_ff, lead_ff, case_ff,
                                        intr_ff, ~state_ff[0]};
          `PXS_TOTAL_ADDR:  rdat_ff <= total_ff;
          `PXS_RCOST_ADDR:  rdat_ff <= row_cost_ff;
          default:          rdat_ff <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Setup registers, writable only while idle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff             <= `PXS_CTRL_RST;
      dest_pointer_ff     <= `PXS_DPTR_RST;
      block_dimensions_ff <= `PXS_DIMS_RST;
      dest_row_pitch_ff   <= `PXS_PITCH_RST;
      pixel_width_reg_ff  <= `PXS_PIXEL_WIDTH_REG_RST;
      src_off_ff          <= `PXS_SOFF_RST;
    end else if (wr_go & state_ff[0]) begin
      case (wb_adr_i)
        `PXS_CTRL_ADDR:  ctrl_ff             <= wsel(ctrl_ff, wb_dat_i, wb_sel_i) & 32'h0000_00f0;
        `PXS_DPTR_ADDR:  dest_pointer_ff     <= wsel(dest_pointer_ff, wb_dat_i, wb_sel_i);
        `PXS_DIMS_ADDR:  block_dimensions_ff <= wsel(block_dimensions_ff, wb_dat_i, wb_sel_i);
        `PXS_PITCH_ADDR: dest_row_pitch_ff   <= wsel(dest_row_pitch_ff, wb_dat_i, wb_sel_i);
        `PXS_PIXEL_WIDTH_REG_ADDR: pixel_width_reg_ff  <= wsel(pixel_width_reg_ff, wb_dat_i, wb_sel_i);
        `PXS_SOFF_ADDR:  src_off_ff          <= wsel(src_off_ff, wb_dat_i, wb_sel_i);
        default:         ctrl_ff             <= ctrl_ff;
      endcase
    end
  end
  wire start_cmd  = wr_go & (wb_adr_i == `PXS_CTRL_ADDR) & wb_sel_i[0]
                  & wb_dat_i[`PXS_CTRL_START];
  wire resume_cmd = wr_go & (wb_adr_i == `PXS_CTRL_ADDR) & wb_sel_i[0]
                  & wb_dat_i[`PXS_CTRL_RESUME];
  // Machine state enable, one memory cycle is two of these
  assign ms_en = (div_ff == `PXS_MS_DIV - 4'h1); // RULE17
  assign nacc     = acc_ff + row_words_ff;
  assign emit_due = state_ff[1] & ms_en & (nacc >= row_cost_ff);
  assign advance  = ms_en & ~(emit_due & ~buf_ready);
  assign buf_data = {rmw_ff, addr_ff};
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (start_cmd) begin
          nxt_state = (block_dimensions_ff[31:16] == 16'h0000 ||
                       block_dimensions_ff[15:0] == 16'h0000) ? S_FINAL : S_ROW;
        end
      end
      S_ROW: begin
        if (advance) begin
          if ((cost_left_ff == 32'h0000_0001) && (rows_left_ff == 16'h0001)) begin
            nxt_state = S_FINAL;
          end else if (irq_req_i && (emit_due || cost_left_ff == 32'h0000_0001)) begin
            nxt_state = S_PAUSE; // RULE16
          end
        end
      end
      S_FINAL: begin
        if (ms_en && cost_left_ff == 32'h0000_0001) begin
          nxt_state = S_IDLE;
        end
      end
      S_PAUSE: begin
        if (resume_cmd) begin
          nxt_state = S_ROW;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= S_IDLE;
      div_ff       <= 4'h0;
      total_ff     <= 32'h0000_0000;
      row_cost_ff  <= 32'h0000_0000;
      row_words_ff <= 32'h0000_0000;
      cost_left_ff <= 32'h0000_0000;
      acc_ff       <= 32'h0000_0000;
      rows_left_ff <= 16'h0000;
      row_base_ff  <= 32'h0000_0000;
      addr_ff      <= 32'h0000_0000;
      rmw_ff       <= 1'b0;
      intr_ff      <= 1'b0;
      case_ff      <= `PXS_CASE_SHORT;
      lead_ff      <= 1'b0;
      trail_ff     <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_ff   <= (ms_en | (state_ff[0] & start_cmd)) ? 4'h0 : div_ff + 4'h1; // RULE17
      if (state_ff[0] && start_cmd) begin
        total_ff     <= 32'h0000_0000;
        row_cost_ff  <= calc_cost;
        row_words_ff <= calc_words;
        cost_left_ff <= (nxt_state == S_FINAL) ? `PXS_FINAL_STATES : calc_cost;
        acc_ff       <= 32'h0000_0000;
        rows_left_ff <= block_dimensions_ff[31:16]; // RULE9
        row_base_ff  <= {dest_pointer_ff[31:4], 4'h0};
        addr_ff      <= {dest_pointer_ff[31:4], 4'h0};
        rmw_ff       <= (ctrl_ff[`PXS_CTRL_MASK] | ctrl_ff[`PXS_CTRL_TRANSP] |
                         (ctrl_ff[`PXS_CTRL_OP_HI:`PXS_CTRL_OP_LO] != 2'h0)); // RULE12
        case_ff      <= calc_case;
        lead_ff      <= lead_mis;
        trail_ff     <= trail_mis;
      end
      if (state_ff[1] && advance) begin
        total_ff <= total_ff + 32'h0000_0001;
        acc_ff   <= emit_due ? nacc - row_cost_ff : nacc;
        addr_ff  <= emit_due ? (addr_ff + `PXS_WORD_BITS) : addr_ff; // RULE11
        if (cost_left_ff == 32'h0000_0001) begin
          rows_left_ff <= rows_left_ff - 16'h0001;
          row_base_ff  <= row_base_ff + dest_row_pitch_ff; // RULE10
          addr_ff      <= row_base_ff + dest_row_pitch_ff; // RULE11
          acc_ff       <= 32'h0000_0000;
          cost_left_ff <= (rows_left_ff == 16'h0001) ? `PXS_FINAL_STATES : row_cost_ff;
        end else begin
          cost_left_ff <= cost_left_ff - 32'h0000_0001;
        end
      end
      if (state_ff[2] && ms_en) begin
        total_ff     <= total_ff + 32'h0000_0001;
        cost_left_ff <= cost_left_ff - 32'h0000_0001;
      end
      if (nxt_state == S_PAUSE && state_ff[1]) begin
        intr_ff <= 1'b1; // RULE16
      end else if (state_ff[3] && resume_cmd) begin
        intr_ff <= 1'b0;
      end
    end
  end
  assign busy_o                   = ~state_ff[0];
  assign block_interrupted_flag_o = intr_ff;
  pxs_buf2 #(
    .W (33)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (emit_due),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_data),
    .out_valid_o (mem_valid_o),
    .out_ready_i (mem_ready_i),
    .out_data_o  ({mem_rmw_o, mem_addr_o})
  );
endmodule // pxs_expand_seq

// ---- verification/pxs_expand_seq_props.sv ----
`timescale 1ns/100ps
module pxs_expand_seq_props (
  input wire        clk_i,
  input wire        rst_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_we_i,
  input wire        wb_stb_i,
  input wire        wb_cyc_i,
  input wire        irq_req_i,
  input wire        mem_valid_o,
  input wire        mem_ready_i,
  input wire [31:0] mem_addr_o,
  input wire        mem_rmw_o,
  input wire        busy_o,
  input wire        block_interrupted_flag_o
);
  reg  [31:0] last_ff;
  reg         seen_ff;
  wire        resume_wr;
  wire        take;

  assign resume_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[1];
  assign take      = mem_valid_o && mem_ready_i;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Last accepted word of the running transfer
  always @(posedge clk_i) begin
    if (rst_i || (!busy_o && !mem_valid_o)) begin
      seen_ff <= 1'b0;
    end else if (take) begin
      seen_ff <= 1'b1;
    end
    if (take) begin
      last_ff <= mem_addr_o;
    end
  end

  a_word_aligned: assert property (mem_valid_o |-> mem_addr_o[3:0] == 4'h0)
    else $error("dest word not aligned");
  a_addr_rising: assert property (take && seen_ff |-> mem_addr_o > last_ff)
    else $error("dest address did not advance");
  a_word_held: assert property (mem_valid_o && !mem_ready_i |=>
    mem_valid_o && $stable(mem_addr_o) && $stable(mem_rmw_o))
    else $error("stalled word changed");
  a_flag_busy: assert property (block_interrupted_flag_o |-> busy_o)
    else $error("paused while idle");
  a_flag_kept: assert property (block_interrupted_flag_o && !resume_wr |=>
    block_interrupted_flag_o)
    else $error("pause ended without resume");
  a_flag_cause: assert property ($rose(block_interrupted_flag_o) |->
    $past(irq_req_i) || $past(irq_req_i, 2) || $past(irq_req_i, 3))
    else $error("pause without request");
  a_irq_latency: assert property (irq_req_i && busy_o && !block_interrupted_flag_o |->
    ##[1:40] (block_interrupted_flag_o || !busy_o))
    else $error("request not seen in time");
  a_final_states: assert property ($rose(busy_o) |-> busy_o[*6])
    else $error("transfer shorter than final states");
endmodule // pxs_expand_seq_props

bind pxs_expand_seq pxs_expand_seq_props u_props (
  .clk_i                    (clk_i),
  .rst_i                    (rst_i),
  .wb_adr_i                 (wb_adr_i),
  .wb_dat_i                 (wb_dat_i),
  .wb_we_i                  (wb_we_i),
  .wb_stb_i                 (wb_stb_i),
  .wb_cyc_i                 (wb_cyc_i),
  .irq_req_i                (irq_req_i),
  .mem_valid_o              (mem_valid_o),
  .mem_ready_i              (mem_ready_i),
  .mem_addr_o               (mem_addr_o),
  .mem_rmw_o                (mem_rmw_o),
  .busy_o                   (busy_o),
  .block_interrupted_flag_o (block_interrupted_flag_o)
);

// ---- verification/pxs_mem_model.sv ----
`timescale 1ns/100ps
module pxs_mem_model (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        slow_i,
  input  wire        mem_valid_i,
  output reg         mem_ready_o,
  input  wire [31:0] mem_addr_i,
  input  wire        mem_rmw_i
);
  reg [2:0]  tick_ff;
  reg [31:0] addr_q[$];
  reg        rmw_q[$];

  // Slow mode accepts one word in eight cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_ff     <= 3'h0;
      mem_ready_o <= 1'b0;
    end else begin
      if (mem_valid_i && mem_ready_o) begin
        addr_q.push_back(mem_addr_i);
        rmw_q.push_back(mem_rmw_i);
      end
      tick_ff     <= tick_ff + 3'h1;
      mem_ready_o <= !slow_i || tick_ff == 3'h7;
    end
  end
endmodule // pxs_mem_model

// ---- verification/pxs_expand_seq_bench.sv ----
`timescale 1ns/100ps
module pxs_expand_seq_bench;
  reg         clk_i, rst_i, cyc, stb, we, irq, slow;
  reg  [7:0]  adr;
  reg  [31:0] dat, rd;
  wire [31:0] dat_o, mem_addr;
  wire        ack, mem_valid, mem_ready, mem_rmw, busy, flag;
  integer     fails, tests_run, i, k, g;

  pxs_expand_seq dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hf), .wb_stb_i(stb), .wb_cyc_i(cyc),
    .wb_ack_o(ack), .irq_req_i(irq), .mem_valid_o(mem_valid), .mem_ready_i(mem_ready),
    .mem_addr_o(mem_addr), .mem_rmw_o(mem_rmw), .busy_o(busy),
    .block_interrupted_flag_o(flag));

  pxs_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_valid_i(mem_valid),
    .mem_ready_o(mem_ready), .mem_addr_i(mem_addr), .mem_rmw_i(mem_rmw));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task report_and_stop;
    begin
      if (fails == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task waitfor(input integer n);
    begin
      if (n <= 0) begin
        fails = fails + 1;
        report_and_stop;
      end
    end
  endtask

  task wb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      n = 100;
      @(posedge clk_i);
      while (ack !== 1'b1 && n > 0) begin
        n = n - 1;
        @(posedge clk_i);
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      waitfor(n);
    end
  endtask

  task run(input [31:0] dp, dims, psz, soff, ctl, rc, nw, cs, input pz);
    integer b, n, wpr;
    begin
      wb(1'b1, 8'h04, dp);
      wb(1'b1, 8'h08, dims);
      wb(1'b1, 8'h0c, 32'h800);
      wb(1'b1, 8'h10, psz);
      wb(1'b1, 8'h14, soff);
      wb(1'b1, 8'h00, ctl);
      b = mem.addr_q.size();
      wpr = nw / dims[31:16];
      wb(1'b1, 8'h00, ctl | 32'h1);
      if (pz) begin
        repeat (10) @(posedge clk_i);
        irq <= 1'b1;
        n = 200;
        while (flag !== 1'b1 && n > 0) begin
          n = n - 1;
          @(posedge clk_i);
        end
        irq <= 1'b0;
        waitfor(n);
        repeat (20) @(posedge clk_i);
        wb(1'b0, 8'h18, 32'h0);
        chk({30'h0, rd[1:0]}, 32'h3);
        wb(1'b1, 8'h00, 32'h2);
      end
      n = 20000;
      @(posedge clk_i);
      while ((busy !== 1'b0 || mem_valid !== 1'b0) && n > 0) begin
        n = n - 1;
        @(posedge clk_i);
      end
      waitfor(n);
      wb(1'b0, 8'h1c, 32'h0);
      chk(rd, dims[31:16] * rc + 3);
      wb(1'b0, 8'h20, 32'h0);
      chk(rd, rc);
      wb(1'b0, 8'h18, 32'h0);
      chk({30'h0, rd[3:2]}, cs);
      chk(mem.addr_q.size() - b, nw);
      for (k = b; k < mem.addr_q.size(); k = k + 1) begin
        chk(mem.addr_q[k], (dp & 32'hffff_fff0) + 32'h10 * ((k - b) % wpr)
          + 32'h800 * ((k - b) / wpr));
        chk({31'h0, mem.rmw_q[k]}, {31'h0, ctl[7:4] != 4'h0});
      end
    end
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
    irq = 1'b0;
    slow = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h18, 32'hff);
    wb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    run(32'h0, 32'h0002_0004, 32'h1, 32'h0, 32'h0, 32'd7, 32'd2, 32'h0, 1'b0);
    // Every operation, plain then masked with a stalling memory
    for (i = 0; i < 8; i = i + 1) begin
      slow <= i[2];
      g = (i[1:0] == 2'h0) ? 2 : i[1:0] + 3 + (i[2] ? 2 : 0);
      if (i == 4) g = 4;
      run(32'h1008, 32'h0002_000a, 32'h8, 32'h8, (i[2] << 6) | (i[1:0] << 4),
        9 + 6 * g - (i[2] ? 4 : 0), 32'd12, 32'h1, 1'b0);
    end
    slow <= 1'b0;
    run(32'h1008, 32'h0001_000b, 32'h8, 32'h8, 32'h0, 32'd19, 32'd6, 32'h1, 1'b0);
    run(32'h1008, 32'h0001_000b, 32'h8, 32'h8, 32'h40, 32'd29, 32'd6, 32'h1, 1'b0);
    run(32'h0, 32'h0001_0028, 32'h1, 32'h0, 32'h0, 32'd15, 32'd3, 32'h2, 1'b0);
    run(32'h0, 32'h0001_0028, 32'h1, 32'h4, 32'h0, 32'd17, 32'd3, 32'h2, 1'b0);
    run(32'h4, 32'h0001_0028, 32'h1, 32'h0, 32'h0, 32'd21, 32'd3, 32'h2, 1'b0);
    run(32'h1008, 32'h0001_000b, 32'h8, 32'h8, 32'h80, 32'd29, 32'd6, 32'h1, 1'b0);
    run(32'h4, 32'h0001_0004, 32'h1, 32'h0, 32'h40, 32'd9, 32'd1, 32'h0, 1'b0);
    run(32'h0, 32'h0000_0004, 32'h1, 32'h0, 32'h0, 32'd7, 32'd0, 32'h0, 1'b0);
    run(32'h1008, 32'h0002_000a, 32'h8, 32'h8, 32'h0, 32'd21, 32'd12, 32'h1, 1'b1);
    report_and_stop;
  end
endmodule // pxs_expand_seq_bench
